// >>> common/tcp_pkg.sv
package tcp_pkg;

    // Counter and bus geometry
    localparam int TCP_CNT_W = 16;
    localparam int TCP_ADDR_W = 5;
    localparam int TCP_DATA_W = 32;
    localparam int TCP_NUM_CHAN = 2;

    // Register byte offsets, one aligned word each
    localparam logic [4:0] TCP_OFS_TIMER_CTRL = 5'h00;
    localparam logic [4:0] TCP_OFS_COUNTER = 5'h04;
    localparam logic [4:0] TCP_OFS_MODULO = 5'h08;
    localparam logic [4:0] TCP_OFS_CHAN0_CTRL = 5'h0c;
    localparam logic [4:0] TCP_OFS_CHAN0_CMP = 5'h10;
    localparam logic [4:0] TCP_OFS_CHAN1_CTRL = 5'h14;
    localparam logic [4:0] TCP_OFS_CHAN1_CMP = 5'h18;
    // Step between the two channel register pairs
    localparam logic [4:0] TCP_OFS_CHAN_STEP = 5'h08;

    // Timer control/status bit positions
    localparam int TCP_BIT_WRAP_FLAG = 7;
    localparam int TCP_BIT_WRAP_IRQ_EN = 6;
    localparam int TCP_BIT_HALT = 5;
    localparam int TCP_BIT_CLEAR = 4;

    // Channel control/status: flag on top, control field below
    localparam int TCP_BIT_CHAN_FLAG = 7;
    localparam int TCP_CHAN_CTRL_W = 7;

    // Reset values
    localparam logic [TCP_CNT_W-1:0] TCP_RST_MODULO = 16'hffff;
    localparam logic [TCP_CNT_W-1:0] TCP_RST_CMP = 16'h0000;
    localparam logic TCP_RST_HALT = 1'b1;

    // Channel control field, bits 6..0 of the channel register
    typedef struct packed {
        logic irq_enable;        // channel_irq_enable
        logic pair_link_select;  // only meaningful in channel 0
        logic out_enable;        // output compare mode
        logic capture_enable;    // input capture on rising pin edge
        logic match_level;       // level forced at a compare match
        logic toggle_on_wrap;
        logic max_duty_select;
    } tcp_chan_ctrl_s;

    localparam tcp_chan_ctrl_s TCP_RST_CHAN_CTRL = 7'h00;

    // Events handed to a channel output stage
    typedef struct packed {
        logic compare_hit;
        logic wrap_hit;
    } tcp_chan_evt_s;

endpackage : tcp_pkg

// >>> verilog/tcp_chan_out.sv
`timescale 1ns/1ns
module tcp_chan_out
    import tcp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic chan_active,
    input tcp_chan_ctrl_s ctrl,
    input tcp_chan_evt_s evt,
    output logic pin_o,
    output logic pin_oe
);

    logic level_reg;
    logic drive_reg;

    assign pin_o = level_reg;
    assign pin_oe = drive_reg;

    // Pin level; compare wins over a wrap toggle in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            level_reg <= 1'b0;
        end else if (chan_active && ctrl.out_enable) begin
            // RQ15: full duty hold
            if (ctrl.max_duty_select && ctrl.toggle_on_wrap) begin
                level_reg <= 1'b1;
            // RQ13: match ends pulse
            end else if (evt.compare_hit) begin
                // RQ14: match forces level only
                level_reg <= ctrl.match_level;
            // RQ12: toggle at wrap
            end else if (evt.wrap_hit && ctrl.toggle_on_wrap) begin
                level_reg <= ~level_reg;
            end
        end
    end

    // Drive only while the channel owns its pin as an output
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            drive_reg <= 1'b0;
        end else begin
            drive_reg <= chan_active && ctrl.out_enable;
        end
    end

endmodule : tcp_chan_out

// >>> verilog/tcp_timer.sv
// Summary of operation
// RQ1: Unlinked channel holds one compare value; a write replaces it directly.
// RQ2: Unsynchronized compare rewrite can miss a match for up to two periods.
// RQ3: Software lowers compare values from inside the channel compare handler.
// RQ4: Software raises compare values from inside the wrap handler.
// RQ5: Larger value written at pulse end can give two matches per period.
// RQ6: Channel flag and request rise when the compare pulse ends.
// RQ7: Wrap flag and request rise when counter reaches the modulo value.
// RQ8: Pair link bit in channel 0 joins channels; output on pin 0.
// RQ9: Channel 0 value acts first; after each wrap last-written set acts.
// RQ10: Linked pair uses channel 0 register only; pin 1 is released.
// RQ11: Software writes only the inactive set; active writes act unbuffered.
// RQ12: PWM output toggles at wrap; wrap interval sets the period.
// RQ13: Pulse width runs from wrap to the channel compare match.
// RQ14: Without toggle on wrap, matches keep level: zero percent duty.
// RQ15: Max duty plus toggle on wrap gives constant full duty output.
// RQ16: Wrap flag sets at modulo; requests interrupt only when enabled.
// RQ17: Channel flag sets on capture or compare; requests when enabled.
// RQ18: Software clears counter halt bit last to start counting.
// RQ19: Wait mode keeps counting, blocks register access, requests wake.
// RQ20: Stop mode freezes counter and registers until stop ends. Bus writes, including the counter clear bit, still take effect during stop.
// RQ21: Each pin is capture or compare; only pin 0 is buffered.
// RQ22: Match is taken on the edge where counter equals active value.
// RQ23: Counter wraps to zero after modulo; buffered sets switch there.
`timescale 1ns/1ns
module tcp_timer
    import tcp_pkg::*;
#(
    parameter int CNT_W = TCP_CNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    // Classic Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TCP_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [TCP_DATA_W-1:0] wb_dat_i,
    output logic [TCP_DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Processor low-power state
    input wire logic wait_mode,
    input wire logic stop_mode,
    // Channel pins, two-way
    input wire logic [TCP_NUM_CHAN-1:0] chan_pin_i,
    output logic [TCP_NUM_CHAN-1:0] chan_pin_o,
    output logic [TCP_NUM_CHAN-1:0] chan_pin_oe,
    // Combined request, also the wake request out of wait mode
    output logic irq_req
);

    // Bus slave and request state
    logic ack_reg;
    logic [TCP_DATA_W-1:0] rdata_reg;
    logic irq_reg;

    // Timer state
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] modulo_reg;
    logic halt_reg;
    logic wrap_irq_en_reg;
    logic wrap_flag_reg;

    // Per-channel state
    tcp_chan_ctrl_s ctrl_reg [TCP_NUM_CHAN];
    logic [TCP_NUM_CHAN-1:0] flag_reg;
    logic [CNT_W-1:0] cmp_reg [TCP_NUM_CHAN];
    logic [TCP_NUM_CHAN-1:0] pin_meta_reg;
    logic [TCP_NUM_CHAN-1:0] pin_sync_reg;
    logic [TCP_NUM_CHAN-1:0] pin_prev_reg;

    // Buffered pair state
    logic active_sel_reg;
    logic last_wr_reg;

    // Decoded bus access, timer and channel events
    logic req;
    logic commit;
    logic wr_commit;
    logic [4:0] word_ofs;
    logic link;
    logic tick;
    logic at_modulo;
    logic wrap_evt;
    logic [TCP_NUM_CHAN-1:0] cmp_wr;
    logic [TCP_NUM_CHAN-1:0] ctrl_wr;
    logic [TCP_NUM_CHAN-1:0] chan_active;
    logic [TCP_NUM_CHAN-1:0] match;
    logic [TCP_NUM_CHAN-1:0] capture;
    logic [TCP_NUM_CHAN-1:0] chan_evt;
    logic [CNT_W-1:0] cmp_active [TCP_NUM_CHAN];
    logic tmr_wr;
    logic [TCP_DATA_W-1:0] rd_mux;

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
    assign irq_req = irq_reg;

    // Request decode; registers are sealed off while in wait mode
    assign req = wb_cyc_i && wb_stb_i;
    assign commit = req && ack_reg;
    // RQ19: no access in wait
    assign wr_commit = commit && wb_we_i && wb_sel_i[0] && !wait_mode;
    assign word_ofs = {wb_adr_i[TCP_ADDR_W-1:2], 2'b00};
    assign tmr_wr = wr_commit && (word_ofs == TCP_OFS_TIMER_CTRL);

    // RQ8: pair link lives in channel 0
    assign link = ctrl_reg[0].pair_link_select;

    // RQ20: stop freezes counting
    assign tick = !halt_reg && !stop_mode;
    assign at_modulo = (count_reg == modulo_reg);
    // RQ7: wrap event at modulo
    assign wrap_evt = tick && at_modulo;

    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req && !ack_reg;
        end
    end

    // Read data captured with the ack; unmapped and wait reads give zero
    always_comb begin
        rd_mux = '0;
        unique case (word_ofs)
            TCP_OFS_TIMER_CTRL: begin
                rd_mux[TCP_BIT_WRAP_FLAG] = wrap_flag_reg;
                rd_mux[TCP_BIT_WRAP_IRQ_EN] = wrap_irq_en_reg;
                rd_mux[TCP_BIT_HALT] = halt_reg;
            end
            TCP_OFS_COUNTER: rd_mux[CNT_W-1:0] = count_reg;
            TCP_OFS_MODULO: rd_mux[CNT_W-1:0] = modulo_reg;
            TCP_OFS_CHAN0_CTRL: begin
                rd_mux[TCP_BIT_CHAN_FLAG] = flag_reg[0];
                rd_mux[TCP_CHAN_CTRL_W-1:0] = ctrl_reg[0];
            end
            TCP_OFS_CHAN0_CMP: rd_mux[CNT_W-1:0] = cmp_reg[0];
            TCP_OFS_CHAN1_CTRL: begin
                rd_mux[TCP_BIT_CHAN_FLAG] = flag_reg[1];
                rd_mux[TCP_CHAN_CTRL_W-1:0] = ctrl_reg[1];
            end
            TCP_OFS_CHAN1_CMP: rd_mux[CNT_W-1:0] = cmp_reg[1];
            default: rd_mux = '0;
        endcase
        if (wait_mode) begin
            rd_mux = '0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else if (req && !ack_reg) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= '0;
        end
    end

    // Free-running counter; clear bit restarts it from zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else if (tmr_wr && wb_dat_i[TCP_BIT_CLEAR]) begin
            count_reg <= '0;
        end else if (tick) begin
            // RQ23: wrap to zero after modulo
            if (at_modulo) begin
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

    // Modulo register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            modulo_reg <= TCP_RST_MODULO[CNT_W-1:0];
        end else if (wr_commit && word_ofs == TCP_OFS_MODULO) begin
            modulo_reg <= wb_dat_i[CNT_W-1:0];
        end
    end

    // Timer control; halt is set from reset so setup happens first
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            halt_reg <= TCP_RST_HALT;
            wrap_irq_en_reg <= 1'b0;
        end else if (tmr_wr) begin
            // RQ18: clearing halt starts counting
            halt_reg <= wb_dat_i[TCP_BIT_HALT];
            wrap_irq_en_reg <= wb_dat_i[TCP_BIT_WRAP_IRQ_EN];
        end
    end

    // Wrap flag, write one to clear; a new wrap beats the clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrap_flag_reg <= 1'b0;
        end else if (wrap_evt) begin
            // RQ16: set at modulo
            wrap_flag_reg <= 1'b1;
        end else if (tmr_wr && wb_dat_i[TCP_BIT_WRAP_FLAG]) begin
            wrap_flag_reg <= 1'b0;
        end
    end

    // Which register set drives the linked output
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            last_wr_reg <= 1'b0;
        end else if (!link) begin
            last_wr_reg <= 1'b0;
        end else if (cmp_wr[1]) begin
            last_wr_reg <= 1'b1;
        end else if (cmp_wr[0]) begin
            last_wr_reg <= 1'b0;
        end
    end

    // Switch only at wraps, so a written inactive set never tears a period
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            active_sel_reg <= 1'b0;
        end else if (!link) begin
            // RQ9: channel 0 acts first
            active_sel_reg <= 1'b0;
        end else if (wrap_evt) begin
            // RQ9: last-written set after wrap
            active_sel_reg <= last_wr_reg;
        end
    end

    // Active compare value per channel
    // RQ21: only pin 0 takes the buffered pair
    assign cmp_active[0] = (link && active_sel_reg) ? cmp_reg[1] : cmp_reg[0];
    assign cmp_active[1] = cmp_reg[1];

    // RQ10: channel 1 idle and pin released
    assign chan_active[0] = 1'b1;
    assign chan_active[1] = !link;

    genvar ch;
    generate
        for (ch = 0; ch < TCP_NUM_CHAN; ch++) begin : g_chan
            localparam logic [4:0] OFS_CTRL = 5'(TCP_OFS_CHAN0_CTRL + ch * TCP_OFS_CHAN_STEP);
            localparam logic [4:0] OFS_CMP = 5'(TCP_OFS_CHAN0_CMP + ch * TCP_OFS_CHAN_STEP);

            assign ctrl_wr[ch] = wr_commit && (word_ofs == OFS_CTRL);
            assign cmp_wr[ch] = wr_commit && (word_ofs == OFS_CMP);

            // RQ22: match on equal edge
            assign match[ch] = tick && chan_active[ch] && ctrl_reg[ch].out_enable
                && (count_reg == cmp_active[ch]);
            assign capture[ch] = chan_active[ch] && !stop_mode
                && ctrl_reg[ch].capture_enable && !ctrl_reg[ch].out_enable
                && pin_sync_reg[ch] && !pin_prev_reg[ch];
            assign chan_evt[ch] = match[ch] || capture[ch];

            // Pin synchroniser; the edge detector compares the second and third stages
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    pin_meta_reg[ch] <= 1'b0;
                    pin_sync_reg[ch] <= 1'b0;
                    pin_prev_reg[ch] <= 1'b0;
                end else begin
                    pin_meta_reg[ch] <= chan_pin_i[ch];
                    pin_sync_reg[ch] <= pin_meta_reg[ch];
                    pin_prev_reg[ch] <= pin_sync_reg[ch];
                end
            end

            // Channel control field
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    ctrl_reg[ch] <= TCP_RST_CHAN_CTRL;
                end else if (ctrl_wr[ch]) begin
                    ctrl_reg[ch] <= tcp_chan_ctrl_s'(wb_dat_i[TCP_CHAN_CTRL_W-1:0]);
                end
            end

            // Compare/capture value; capture beats a bus write
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    cmp_reg[ch] <= TCP_RST_CMP[CNT_W-1:0];
                end else if (capture[ch]) begin
                    cmp_reg[ch] <= count_reg;
                end else if (cmp_wr[ch]) begin
                    // RQ1: write replaces value
                    // RQ2: no resync of a late write
                    // RQ5: second match in period allowed
                    cmp_reg[ch] <= wb_dat_i[CNT_W-1:0];
                end
            end

            // Channel flag, write one to clear; a new event beats the clear
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    flag_reg[ch] <= 1'b0;
                end else if (chan_evt[ch]) begin
                    // RQ6: flag at pulse end
                    // RQ17: set on compare or capture
                    flag_reg[ch] <= 1'b1;
                end else if (ctrl_wr[ch] && wb_dat_i[TCP_BIT_CHAN_FLAG]) begin
                    flag_reg[ch] <= 1'b0;
                end
            end

            tcp_chan_out u_out (
                .clock(clock),
                .rst_n(rst_n),
                .chan_active(chan_active[ch]),
                .ctrl(ctrl_reg[ch]),
                .evt('{compare_hit: match[ch], wrap_hit: wrap_evt}),
                .pin_o(chan_pin_o[ch]),
                .pin_oe(chan_pin_oe[ch])
            );
        end
    endgenerate

    // Request and wake line: any enabled flag (channel 1 only while unlinked), stays up through wait
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            // RQ16: wrap request gated
            // RQ17: channel request gated
            // RQ19: wakes processor
            irq_reg <= (wrap_flag_reg && wrap_irq_en_reg)
                || (flag_reg[0] && ctrl_reg[0].irq_enable)
                || (flag_reg[1] && ctrl_reg[1].irq_enable && !link);
        end
    end

endmodule : tcp_timer

// >>> test/tcp_timer_sva.sv
`timescale 1ns/1ns
module tcp_timer_sva
    import tcp_pkg::*;
#(
    parameter int CNT_W = TCP_CNT_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [TCP_DATA_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wait_mode,
    input wire logic stop_mode,
    input wire logic [TCP_NUM_CHAN-1:0] chan_pin_o,
    input wire logic irq_req
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    // Open request not yet answered
    sequence s_req_open;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // Four stopped edges; the late flag and request stages need the extra edge to settle
    sequence s_stop_quiet;
        (stop_mode && !wb_ack_o) [*3] ##1 stop_mode;
    endsequence

    a_ack_next: assert property (s_req_open |=> wb_ack_o) // bus handshake
        else $error("no ack one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) // bus handshake
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) // bus handshake
        else $error("ack without request");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == '0) // bus handshake
        else $error("read data not zero outside ack");
    a_wait_read: assert property (wb_ack_o && $past(wait_mode) && !$past(wb_we_i)
        |-> wb_dat_o == '0)
        else $error("register readable in wait mode");
    a_wait_wake: assert property (wait_mode && irq_req |=> irq_req)
        else $error("wake request dropped in wait mode");
    a_stop_pins: assert property (s_stop_quiet |-> $stable(chan_pin_o))
        else $error("pin moved in stop mode");
    a_stop_irq: assert property (s_stop_quiet |-> $stable(irq_req))
        else $error("request moved in stop mode");
endmodule : tcp_timer_sva

bind tcp_timer tcp_timer_sva #(.CNT_W(CNT_W)) u_sva (
    .clock(clock),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .wait_mode(wait_mode),
    .stop_mode(stop_mode),
    .chan_pin_o(chan_pin_o),
    .irq_req(irq_req)
);

// >>> test/tcp_pin_model.sv
`timescale 1ns/1ns
module tcp_pin_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] pin_drv,
    input wire logic [1:0] pin_en,
    output logic [1:0] pin_lvl
);
    logic [1:0] last_reg;

    // Remember the wire level; no pull on these pins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            last_reg <= 2'b00;
        end else begin
            last_reg <= pin_lvl;
        end
    end

    // per pin resolution
    // Released pin floats, shown as a level that flips every cycle
    assign pin_lvl = (pin_en & pin_drv) | (~pin_en & ~last_reg);
endmodule : tcp_pin_model

// >>> test/tcp_timer_bench.sv
`timescale 1ns/1ns
module tcp_timer_bench
    import tcp_pkg::*;
;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cyc, stb, we, wait_m, stop_m, ack, irq;
    logic [4:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [1:0] p_o, p_oe, p_i;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    // 10 MHz
    always #50 clock = ~clock;

    tcp_timer #(.CNT_W(TCP_CNT_W)) i_dut (
        .clock(clock), .rst_n(rst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack),
        .wait_mode(wait_m), .stop_mode(stop_m),
        .chan_pin_i(p_i), .chan_pin_o(p_o), .chan_pin_oe(p_oe),
        .irq_req(irq)
    );

    tcp_pin_model u_pins (
        .clock(clock), .rst_n(rst_n), .pin_drv(p_o), .pin_en(p_oe), .pin_lvl(p_i)
    );

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // One classic cycle; the wait for ack is bounded
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        {cyc, stb} <= 2'b00;
        if (n >= 20) num_errors++;
    endtask : wb

    task automatic rd(input logic [4:0] a, input string nm, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(nm, e, q);
    endtask : rd

    // High cycles of pin 0 over 100 cycles, after settling
    task automatic duty(input logic [31:0] e);
        logic [31:0] h;
        h = '0;
        repeat (20) @(posedge clock);
        repeat (100) begin
            @(posedge clock);
            h = h + p_o[0];
        end
        chk("duty", e, h);
    endtask : duty

    task automatic t_regs;
        rd(TCP_OFS_MODULO, "modulo", 32'hffff);
        rd(TCP_OFS_TIMER_CTRL, "tctrl", 32'h20);
        rd(TCP_OFS_CHAN0_CTRL, "c0ctrl", 32'h0);
        rd(5'h1c, "unmapped", 32'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_wrap;
        wb(TCP_OFS_MODULO, 1'b1, 32'h4);
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'h0);
        repeat (10) @(posedge clock);
        rd(TCP_OFS_TIMER_CTRL, "wrap_flag", 32'h80);
        chk("masked_irq", 32'h0, irq);
        // Halt first so no wrap can land on the clearing write
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'h20);
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'he0);
        rd(TCP_OFS_TIMER_CTRL, "flag_clr", 32'h60);
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'h40);
        repeat (10) @(posedge clock);
        chk("wrap_irq", 32'h1, irq);
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'ha0);
        $display("t_wrap done");
    endtask : t_wrap

    task automatic t_pwm;
        logic [7:0] mode [4] = '{8'h12, 8'h10, 8'h13, 8'h12};
        logic [31:0] cmp [4] = '{32'd2, 32'd2, 32'd2, 32'd5};
        logic [31:0] high [4] = '{32'd30, 32'd0, 32'd100, 32'd60};
        wb(TCP_OFS_MODULO, 1'b1, 32'h9);
        wb(TCP_OFS_CHAN0_CMP, 1'b1, 32'h2);
        wb(TCP_OFS_CHAN0_CTRL, 1'b1, 32'h12);
        wb(TCP_OFS_TIMER_CTRL, 1'b1, 32'h0);
        repeat (12) @(posedge clock);
        rd(TCP_OFS_CHAN0_CTRL, "chan_flag", 32'h92);
        for (int i = 0; i < 4; i++) begin
            wb(TCP_OFS_CHAN0_CMP, 1'b1, cmp[i]);
            wb(TCP_OFS_CHAN0_CTRL, 1'b1, {24'h0, mode[i]});
            duty(high[i]);
        end
        chk("oe0", 32'h1, p_oe[0]);
        chk("pin_in", {31'h0, p_o[0]}, {31'h0, p_i[0]});
        $display("t_pwm done");
    endtask : t_pwm

    task automatic t_link;
        wb(TCP_OFS_CHAN1_CTRL, 1'b1, 32'h12);
        wb(TCP_OFS_CHAN0_CTRL, 1'b1, 32'h32);
        duty(32'd60);
        wb(TCP_OFS_CHAN1_CMP, 1'b1, 32'h6);
        duty(32'd70);
        wb(TCP_OFS_CHAN0_CMP, 1'b1, 32'h3);
        duty(32'd40);
        chk("oe1", 32'h0, p_oe[1]);
        $display("t_link done");
    endtask : t_link

    task automatic t_wait;
        wb(TCP_OFS_CHAN0_CTRL, 1'b1, 32'h72);
        @(posedge clock);
        wait_m <= 1'b1;
        repeat (12) @(posedge clock);
        chk("wake", 32'h1, irq);
        rd(TCP_OFS_MODULO, "wait_rd", 32'h0);
        wb(TCP_OFS_MODULO, 1'b1, 32'h3);
        wait_m <= 1'b0;
        rd(TCP_OFS_MODULO, "wait_wr", 32'h9);
        $display("t_wait done");
    endtask : t_wait

    task automatic t_stop;
        logic [31:0] c0;
        @(posedge clock);
        stop_m <= 1'b1;
        wb(TCP_OFS_COUNTER, 1'b0, 32'h0);
        c0 = q;
        repeat (8) @(posedge clock);
        rd(TCP_OFS_COUNTER, "frozen", c0);
        stop_m <= 1'b0;
        $display("t_stop done");
    endtask : t_stop

    // Hang guard, well above the expected run length
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            num_errors++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        {cyc, stb, we, wait_m, stop_m} = 5'h00;
        adr = 5'h00;
        wdat = 32'h0;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_wrap();
        t_pwm();
        t_link();
        t_wait();
        t_stop();
        close_out();
    end
endmodule : tcp_timer_bench
